/* File: src/blcx_core.sv */
// execute stage for bit, and, clear and call operations
//
// Behaviour
// - bit_clear_op forces bit b of file f to zero, keeps the other bits and keeps all flags.
// - bit_set_op forces bit b of file f to one, keeps the other bits and keeps all flags.
// - and_literal_op ands the accumulator with an 8-bit immediate into the accumulator, touching only the nil flag.
// - and_reg_op ands the accumulator with file f, touching only the nil flag among the flags.
// - a destination bit of 0 sends the result to the accumulator, 1 writes it back into file f.
// - skip_if_bit_low discards the fetched next instruction as a no-op when bit b of f is zero, taking two cycles.
// - skip_if_bit_high discards the fetched next instruction as a no-op when bit b of f is one, flags unchanged.
// - clear_accum_op loads zero into the accumulator and always sets the nil flag.
// - a call first pushes the current program counter plus one onto the return stack.
// - a call target takes bits 7:0 from the immediate, bits 10:9 from status 6:5, and bit 8 cleared.
// - a call takes two cycles and alters no status flag.
// - read-modify-write of the port register reads the pin levels, not the output latch.
`timescale 1ns/10ps
`include "blcx_cfg.svh"
module blcx_core (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             instr_valid,
	input  wire logic [11:0]      instr,
	input  wire blcx_pkg::blcx_pc_t pc_now,
	input  wire logic [7:0]       pin_level,
	output blcx_pkg::blcx_byte_t  accum,
	output blcx_pkg::blcx_byte_t  status_out,
	output blcx_pkg::blcx_byte_t  port_latch,
	output logic                  pc_load,
	output blcx_pkg::blcx_pc_t    pc_target,
	output logic                  push_en,
	output blcx_pkg::blcx_pc_t    push_addr,
	output logic                  discard
);
	import blcx_pkg::*;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	blcx_byte_t  file_mem [0:31];
	blcx_state_e state;
	blcx_state_e next_state;
	logic [7:0]  pin_s1;
	logic [7:0]  pin_s2;
	logic [7:0]  pin_s3;
	logic [7:0]  pin_stable;

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	// a level is accepted only once the last two stages agree
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1 <= `BLCX_BYTE_ZERO;
			pin_s2 <= `BLCX_BYTE_ZERO;
			pin_s3 <= `BLCX_BYTE_ZERO;
		end else begin
			pin_s1 <= pin_level;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_stable <= `BLCX_BYTE_ZERO;
		end else if (pin_s2 == pin_s3) begin
			pin_stable <= pin_s3;
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic       exec;
	logic [4:0] f_idx;
	logic [2:0] b_idx;
	logic       dest_f;
	logic [7:0] k_lit;
	logic       is_bcf;
	logic       is_bsf;
	logic       is_slo;
	logic       is_shi;
	logic       is_and_reg_op;
	logic       is_and_literal_op;
	logic       is_clear_accum_op;
	logic       is_call;
	logic [7:0] rd_val;
	logic [7:0] clr_res;
	logic [7:0] set_res;
	logic [7:0] and_res;
	logic [7:0] and_lit;
	logic       bit_val;
	logic       and_zero;
	logic       skip_take;

	always_comb begin
		// a fetched word arriving in flush is dropped, so it decodes to nothing
		exec = instr_valid && (state == BLCX_EXEC);
		f_idx = instr[4:0];
		b_idx = instr[7:5];
		dest_f = instr[5];
		k_lit = instr[7:0];
		is_bcf = exec && (instr[11:8] == `BLCX_OP_BCF);
		is_bsf = exec && (instr[11:8] == `BLCX_OP_BSF);
		is_slo = exec && (instr[11:8] == `BLCX_OP_SKIPLO);
		is_shi = exec && (instr[11:8] == `BLCX_OP_SKIPHI);
		is_and_reg_op = exec && (instr[11:6] == `BLCX_OP_AND_REG_OP);
		is_and_literal_op = exec && (instr[11:8] == `BLCX_OP_AND_LITERAL_OP);
		is_clear_accum_op = exec && (instr == `BLCX_OP_CLEAR_ACCUM_OP);
		is_call = exec && (instr[11:8] == `BLCX_OP_CALL);
		rd_val = (f_idx == `BLCX_PORT_ADDR) ? pin_stable : file_mem[f_idx];
		and_lit = accum & k_lit;
		skip_take = (is_slo && !bit_val) || (is_shi && bit_val);
	end

	blcx_alu u_alu (
		.opnd     (rd_val),
		.accv     (accum),
		.bsel     (b_idx),
		.clr_res  (clr_res),
		.set_res  (set_res),
		.and_res  (and_res),
		.bit_val  (bit_val),
		.and_zero (and_zero)
	);

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			BLCX_EXEC: begin
				if (skip_take || is_call) begin
					next_state = BLCX_FLUSH;
				end
			end
			BLCX_FLUSH: begin
				if (instr_valid) begin
					next_state = BLCX_EXEC;
				end
			end
			default: begin
				next_state = BLCX_EXEC;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= BLCX_EXEC;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			discard <= 1'b0;
		end else begin
			discard <= (state == BLCX_FLUSH) && instr_valid;
		end
	end

	// ----------------------------------------
	// file registers and nil flag
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 32; i++) begin
				file_mem[i] <= `BLCX_BYTE_ZERO;
			end
		end else begin
			if (is_bcf) begin
				file_mem[f_idx] <= clr_res;
			end
			if (is_bsf) begin
				file_mem[f_idx] <= set_res;
			end
			if (is_and_reg_op && dest_f) begin
				file_mem[f_idx] <= and_res;
			end
			if (is_and_reg_op) begin
				file_mem[`BLCX_STATUS_ADDR][`BLCX_ZERO_BIT] <= and_zero;
			end
			if (is_and_literal_op) begin
				file_mem[`BLCX_STATUS_ADDR][`BLCX_ZERO_BIT] <= (and_lit == `BLCX_BYTE_ZERO);
			end
			if (is_clear_accum_op) begin
				file_mem[`BLCX_STATUS_ADDR][`BLCX_ZERO_BIT] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// accumulator
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			accum <= `BLCX_BYTE_ZERO;
		end else if (is_and_literal_op) begin
			accum <= and_lit;
		end else if (is_and_reg_op && !dest_f) begin
			accum <= and_res;
		end else if (is_clear_accum_op) begin
			accum <= `BLCX_BYTE_ZERO;
		end
	end

	assign status_out = file_mem[`BLCX_STATUS_ADDR];
	assign port_latch = file_mem[`BLCX_PORT_ADDR];

	// ----------------------------------------
	// call and program counter
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_load   <= 1'b0;
			push_en   <= 1'b0;
			pc_target <= '0;
			push_addr <= '0;
		end else begin
			pc_load <= is_call;
			push_en <= is_call;
			if (is_call) begin
				push_addr <= pc_now + `BLCX_PC_STEP;
				pc_target <= {status_out[`BLCX_PAGE_HI:`BLCX_PAGE_LO], 1'b0, k_lit};
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_bcf;
		@(posedge clk) disable iff (!resetn)
		is_bcf && (f_idx != `BLCX_STATUS_ADDR) |=> !file_mem[$past(f_idx)][$past(b_idx)];
	endproperty
	a_bcf: assert property (p_bcf) else $error("bit clear left bit set");

	property p_bsf;
		@(posedge clk) disable iff (!resetn)
		is_bsf |=> file_mem[$past(f_idx)][$past(b_idx)];
	endproperty
	a_bsf: assert property (p_bsf) else $error("bit set left bit clear");

	property p_and_literal_op;
		@(posedge clk) disable iff (!resetn)
		is_and_literal_op |=> (accum == ($past(accum) & $past(k_lit)))
			&& (status_out[`BLCX_ZERO_BIT] == (accum == 8'h00));
	endproperty
	a_and_literal_op: assert property (p_and_literal_op) else $error("literal and wrong");

	property p_and_reg_op_w;
		@(posedge clk) disable iff (!resetn)
		is_and_reg_op && !dest_f |=> (accum == $past(and_res)) && (status_out[`BLCX_ZERO_BIT] == (accum == 8'h00));
	endproperty
	a_and_reg_op_w: assert property (p_and_reg_op_w) else $error("register and to accumulator wrong");

	property p_and_reg_op_f;
		@(posedge clk) disable iff (!resetn)
		is_and_reg_op && dest_f && (f_idx != `BLCX_STATUS_ADDR) |=> $stable(accum)
			&& (file_mem[$past(f_idx)] == $past(and_res));
	endproperty
	a_and_reg_op_f: assert property (p_and_reg_op_f) else $error("register and to file wrong");

	property p_skip;
		@(posedge clk) disable iff (!resetn)
		skip_take ##1 instr_valid |=> discard && $stable(accum) && $stable(status_out);
	endproperty
	a_skip: assert property (p_skip) else $error("skip did not discard cleanly");

	property p_noskip;
		@(posedge clk) disable iff (!resetn)
		(is_slo || is_shi) && !skip_take |=> (state == BLCX_EXEC) && $stable(status_out);
	endproperty
	a_noskip: assert property (p_noskip) else $error("skip test stalled without skip");

	property p_clear_accum_op;
		@(posedge clk) disable iff (!resetn)
		is_clear_accum_op |=> (accum == 8'h00) && status_out[`BLCX_ZERO_BIT];
	endproperty
	a_clear_accum_op: assert property (p_clear_accum_op) else $error("clear accumulator wrong");

	property p_call;
		@(posedge clk) disable iff (!resetn)
		is_call |=> push_en && pc_load && (push_addr == $past(pc_now) + 11'h001)
			&& (pc_target[8] == 1'b0) && (pc_target[10:9] == $past(status_out[6:5]))
			&& (pc_target[7:0] == $past(k_lit)) && (state == BLCX_FLUSH) && $stable(status_out);
	endproperty
	a_call: assert property (p_call) else $error("call target or push wrong");

	c_call:   cover property (@(posedge clk) disable iff (!resetn) is_call ##1 instr_valid);
	c_skiplo: cover property (@(posedge clk) disable iff (!resetn) is_slo && skip_take);
	c_skiphi: cover property (@(posedge clk) disable iff (!resetn) is_shi && skip_take);
	c_port:   cover property (@(posedge clk) disable iff (!resetn) is_bsf && (f_idx == `BLCX_PORT_ADDR));
endmodule

/* File: src/blcx_cfg.svh */
// constants for the bit logic and call execute block
`ifndef BLCX_CFG_SVH
`define BLCX_CFG_SVH
`define BLCX_OP_CLEAR_ACCUM_OP      12'h040
`define BLCX_OP_AND_REG_OP     6'h05
`define BLCX_OP_BCF       4'h4
`define BLCX_OP_BSF       4'h5
`define BLCX_OP_SKIPLO    4'h6
`define BLCX_OP_SKIPHI    4'h7
`define BLCX_OP_CALL      4'h9
`define BLCX_OP_AND_LITERAL_OP     4'hE
`define BLCX_STATUS_ADDR  5'h03
`define BLCX_PORT_ADDR    5'h06
`define BLCX_ZERO_BIT     3'h2
`define BLCX_PAGE_HI      6
`define BLCX_PAGE_LO      5
`define BLCX_BYTE_ZERO    8'h00
`define BLCX_PC_STEP      11'h001
`endif

/* File: src/blcx_pkg.sv */
// types for the bit logic and call execute block
package blcx_pkg;
	typedef enum logic [0:0] {
		BLCX_EXEC  = 1'b0,
		BLCX_FLUSH = 1'b1
	} blcx_state_e;
	typedef logic [7:0]  blcx_byte_t;
	typedef logic [10:0] blcx_pc_t;
endpackage

/* File: src/blcx_alu.sv */
// bit and logic arithmetic unit
`timescale 1ns/10ps
module blcx_alu (
	input  wire logic [7:0] opnd,
	input  wire logic [7:0] accv,
	input  wire logic [2:0] bsel,
	output logic      [7:0] clr_res,
	output logic      [7:0] set_res,
	output logic      [7:0] and_res,
	output logic            bit_val,
	output logic            and_zero
);
	always_comb begin
		clr_res = opnd & ~(8'h01 << bsel);
		set_res = opnd | (8'h01 << bsel);
		and_res = opnd & accv;
		bit_val = opnd[bsel];
		and_zero = ((opnd & accv) == 8'h00);
	end
endmodule

/* File: test/bit_logic_call_execute_tb.sv */
// self-checking testbench for the bit logic and call execute block
`timescale 1ns/10ps
`include "blcx_cfg.svh"
module bit_logic_call_execute_tb;
	import blcx_pkg::*;
	logic        clk         = 1'b0;
	logic        resetn      = 1'b0;
	logic        instr_valid = 1'b0;
	logic [11:0] instr       = 12'h000;
	blcx_pc_t    pc_now      = 11'h000;
	logic [7:0]  pin_level   = 8'h00;
	blcx_byte_t  accum;
	blcx_byte_t  status_out;
	blcx_byte_t  port_latch;
	logic        pc_load;
	logic        push_en;
	logic        discard;
	blcx_pc_t    pc_target;
	blcx_pc_t    push_addr;
	int          n_errors    = 0;
	int          comparisons = 0;

	always #2.5 clk = ~clk;

	blcx_core i_blcx_core (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
		.pc_now(pc_now), .pin_level(pin_level), .accum(accum), .status_out(status_out),
		.port_latch(port_latch), .pc_load(pc_load), .pc_target(pc_target), .push_en(push_en),
		.push_addr(push_addr), .discard(discard));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [11:0] bop(input logic [3:0] op, input logic [2:0] b, input logic [4:0] f);
		return {op, b, f};
	endfunction

	task automatic put(input logic [11:0] w);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= w;
	endtask

	// idle cycles, then sample once the last edge has landed
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			instr_valid <= 1'b0;
		end
		#1;
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_flags();
		put(`BLCX_OP_CLEAR_ACCUM_OP);
		idle(1);
		chk("accum clear", accum, 8'h00);
		chk("nil set", status_out, 8'h04);
		put(bop(`BLCX_OP_BSF, 3'h5, `BLCX_STATUS_ADDR));
		put(bop(`BLCX_OP_BSF, 3'h6, `BLCX_STATUS_ADDR));
		put(bop(`BLCX_OP_BCF, 3'h2, `BLCX_STATUS_ADDR));
		idle(1);
		chk("status bit ops", status_out, 8'h60);
		put({`BLCX_OP_AND_LITERAL_OP, 8'h5A});
		idle(1);
		chk("and literal nil", status_out, 8'h64);
		chk("and literal acc", accum, 8'h00);
	endtask

	// port writes take the synced pin levels, 4 cycles behind
	task automatic t_port();
		@(posedge clk);
		pin_level <= 8'hA0;
		idle(6);
		put(bop(`BLCX_OP_BSF, 3'h0, `BLCX_PORT_ADDR));
		idle(1);
		chk("set port bit0", port_latch, 8'hA1);
		@(posedge clk);
		pin_level <= 8'hFF;
		idle(6);
		put(bop(`BLCX_OP_BCF, 3'h7, `BLCX_PORT_ADDR));
		idle(1);
		chk("clear port bit7", port_latch, 8'h7F);
		chk("flags kept", status_out, 8'h64);
		put(bop(`BLCX_OP_BCF, 3'h2, `BLCX_STATUS_ADDR));
		put({`BLCX_OP_AND_REG_OP, 1'b0, `BLCX_PORT_ADDR});
		idle(1);
		chk("and reg d0 port", port_latch, 8'h7F);
		chk("and reg d0 nil", status_out, 8'h64);
		@(posedge clk);
		pin_level <= 8'h00;
		put(bop(`BLCX_OP_BCF, 3'h2, `BLCX_STATUS_ADDR));
		put({`BLCX_OP_AND_REG_OP, 1'b1, `BLCX_PORT_ADDR});
		idle(1);
		chk("and reg d1 port", port_latch, 8'h00);
		chk("and reg d1 nil", status_out, 8'h64);
	endtask

	task automatic t_skip();
		put(bop(`BLCX_OP_BSF, 3'h4, 5'h0A));
		put(bop(`BLCX_OP_SKIPHI, 3'h4, 5'h0A));
		put(bop(`BLCX_OP_BSF, 3'h1, `BLCX_PORT_ADDR));
		idle(1);
		chk("skip high discard", discard, 1'b1);
		chk("dropped word", port_latch, 8'h00);
		put(bop(`BLCX_OP_SKIPLO, 3'h4, 5'h0A));
		put(bop(`BLCX_OP_BSF, 3'h1, `BLCX_PORT_ADDR));
		idle(1);
		chk("no skip low", discard, 1'b0);
		chk("next word runs", port_latch, 8'h02);
		put(bop(`BLCX_OP_SKIPLO, 3'h3, 5'h0A));
		put(bop(`BLCX_OP_BCF, 3'h5, `BLCX_STATUS_ADDR));
		idle(1);
		chk("skip low discard", discard, 1'b1);
		chk("status after skip", status_out, 8'h64);
		put(bop(`BLCX_OP_SKIPHI, 3'h3, 5'h0A));
		put(bop(`BLCX_OP_BSF, 3'h2, `BLCX_PORT_ADDR));
		idle(1);
		chk("no skip high", port_latch, 8'h04);
	endtask

	task automatic t_call();
		@(posedge clk);
		pc_now <= 11'h1FF;
		put({`BLCX_OP_CALL, 8'hA5});
		put(bop(`BLCX_OP_BSF, 3'h7, `BLCX_PORT_ADDR));
		#1;
		chk("push pulse", push_en, 1'b1);
		chk("return addr", push_addr, 11'h200);
		chk("load pulse", pc_load, 1'b1);
		chk("call target", pc_target, 11'h6A5);
		idle(1);
		chk("call discard", discard, 1'b1);
		chk("call port", port_latch, 8'h04);
		chk("call flags", status_out, 8'h64);
		idle(1);
		chk("load one cycle", pc_load, 1'b0);
		chk("target holds", pc_target, 11'h6A5);
	endtask

	// ----------------------------------------
	// sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		idle(1);
		chk("accum reset", accum, 8'h00);
		chk("status reset", status_out, 8'h00);
		t_flags();
		t_port();
		t_skip();
		t_call();
		report_and_stop();
	end

	// whole run is under a hundred cycles
	initial begin
		#10000;
		n_errors++;
		report_and_stop();
	end
endmodule
